// file: logic/fpa_pkg.sv
`default_nettype none
package fpa_pkg;

	// ------------------------------------------------------------
	// Modes and cell kinds
	// ------------------------------------------------------------
	typedef enum logic [1:0] {MODE_OFF, MODE_UTOPIA, MODE_NIBBLE, MODE_SERIAL} fpa_mode_t;
	typedef enum logic {CELL_IDLE, CELL_DATA} fpa_cell_t;

	// ------------------------------------------------------------
	// Widths and counts
	// ------------------------------------------------------------
	localparam int unsigned OCTET_W     = 8;
	localparam int unsigned FIFO_DEPTH  = 16;
	localparam int unsigned CELL_OCTETS = 53;
	localparam logic [5:0]  CELL_LAST   = 6'h34;  // 53 octets, index 0 to 52
	localparam logic [2:0]  BEATS_UTO   = 3'h0;   // Last beat index per octet
	localparam logic [2:0]  BEATS_NIB   = 3'h1;
	localparam logic [2:0]  BEATS_SER   = 3'h7;
	localparam int unsigned TX_PINS     = 5;      // Port A bits 22..18
	localparam int unsigned RX_PINS     = 5;      // Port A bits 17..13
	localparam int unsigned RX_LOW      = 3;      // Receive lanes 2..0
	localparam int unsigned IDENT_W     = 6;
	localparam int unsigned IDENT_PIN   = 2;      // Code bit on port A bit 13
	localparam int unsigned IDENT_DIR   = 5;      // 0 transmit, 1 receive

	// ------------------------------------------------------------
	// Idle cell contents and fill octets
	// ------------------------------------------------------------
	localparam logic [5:0] IDLE_HDR_IDX = 6'h03;
	localparam logic [5:0] IDLE_HEC_IDX = 6'h04;
	localparam logic [7:0] IDLE_HDR_OCT = 8'h01;
	localparam logic [7:0] IDLE_HEC_OCT = 8'h52;
	localparam logic [7:0] IDLE_PAY_OCT = 8'h6A;
	localparam logic [7:0] ZERO_OCT     = 8'h00;
	localparam logic [7:0] FLAG_OCT     = 8'h7E;

endpackage
`default_nettype wire

// file: logic/fpa_fifo.sv
`default_nettype none
module fpa_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             srst,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);

	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [CW-1:0]    count_reg;
	logic [WIDTH-1:0] out_data_reg;
	logic             out_valid_reg;
	wire              push;
	wire              load;

	// ------------------------------------------------------------
	// Handshake terms
	// ------------------------------------------------------------
	assign in_ready  = (count_reg != CW'(DEPTH));
	assign push      = ce && in_valid && in_ready;
	assign load      = ce && (count_reg != '0) && (!out_valid_reg || out_ready);
	assign out_data  = out_data_reg;
	assign out_valid = out_valid_reg;

	// Storage array, no reset needed
	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	// Pointers, level and registered read stage
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			wr_ptr_reg    <= '0;
			rd_ptr_reg    <= '0;
			count_reg     <= '0;
			out_data_reg  <= '0;
			out_valid_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (push)
				wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
			if (load)
			begin
				rd_ptr_reg   <= AW'(rd_ptr_reg + 1'b1);
				out_data_reg <= mem_reg[rd_ptr_reg];
			end
			count_reg <= CW'(count_reg + CW'(push) - CW'(load));
			if (load)
				out_valid_reg <= 1'b1;
			else if (out_ready)
				out_valid_reg <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// file: logic/fpa_lanes.sv
// Contract
// - In cell mode bits 7..3 of each transmitted octet go out on five lanes, lane 7 most significant; bits 2..0 are not sent.
// - With no payload queued, the cell-mode transmitter sends idle cells.
// - Every cell sent or received is 53 octets and the cell counters wrap at that length.
// - In cell mode received octets come in on eight lanes, lane 7 most significant; lane 3 reads 0 while pin 13 drives the identity code.
// - In nibble mode four bits go out at a time on lanes 3 to 0, lane 3 most significant.
// - In nibble mode four bits come in at a time on lanes 3 to 0, lane 3 most significant.
// - In serial mode data goes out on one single-bit lane.
// - In serial mode data comes in on one single-bit lane.
// - Pins 22..18 carry cell lanes 3..7, pins 21..18 nibble lanes 3..0, pin 18 serial out.
// - Pins 17..13 carry cell lanes 7..3, pins 17..14 nibble lanes 0..3, pin 17 serial in.
// - A six-bit identity code names the DMA user, bits 0..4 its sub-block, pin 13 bit 2.
// - Identity bit 5 is 0 for a transmit transfer and 1 for a receive transfer.
// - The identity code of a failing DMA transfer is captured for software.
`default_nettype none
module fpa_lanes #(
	parameter int unsigned FIFO_DEPTH = fpa_pkg::FIFO_DEPTH
) (
	input  wire logic                               clk_sys,
	input  wire logic                               srst,
	input  wire logic                               ce,
	input  wire fpa_pkg::fpa_mode_t                 lane_mode,
	input  wire logic                               ident_sel,
	input  wire logic [fpa_pkg::OCTET_W-1:0]        tx_data,
	input  wire logic                               tx_valid,
	output logic                                    tx_ready,
	output logic                                    tx_underrun,
	output logic [fpa_pkg::TX_PINS-1:0]             tx_pin_out,
	output logic [fpa_pkg::TX_PINS-1:0]             tx_pin_oe,
	input  wire logic [fpa_pkg::RX_PINS-1:0]        rx_pin_in,
	input  wire logic [fpa_pkg::RX_LOW-1:0]         rx_low_in,
	input  wire logic                               rx_enable_strobe,
	output logic [fpa_pkg::OCTET_W-1:0]             rx_data,
	output logic                                    rx_valid,
	output logic                                    rx_cell_end,
	input  wire logic [fpa_pkg::IDENT_W-2:0]        ident_sub_code,
	input  wire logic                               ident_rx_section,
	input  wire logic                               dma_error,
	input  wire logic                               err_clear,
	output logic [fpa_pkg::IDENT_W-1:0]             module_ident_code,
	output logic [fpa_pkg::IDENT_W-1:0]             err_ident_code,
	output logic                                    err_flag,
	output logic                                    port_a_bit_13_out,
	output logic                                    port_a_bit_13_oe
);

	localparam int unsigned W = fpa_pkg::OCTET_W;
	localparam int unsigned SYNC_W = fpa_pkg::RX_PINS + fpa_pkg::RX_LOW + 1;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	fpa_pkg::fpa_mode_t  mode_reg;
	fpa_pkg::fpa_cell_t  kind_reg;
	fpa_pkg::fpa_cell_t  kind_next;
	logic [W-1:0]        sh_reg;
	logic [W-1:0]        sh_next;
	logic [2:0]          beat_reg;
	logic [5:0]          tx_cnt_reg;
	wire  [fpa_pkg::TX_PINS-1:0] pin_next;
	logic [fpa_pkg::TX_PINS-1:0] pin_out_reg;
	logic [fpa_pkg::TX_PINS-1:0] pin_oe_reg;
	logic                underrun_reg;
	logic [SYNC_W-1:0]   s1_reg;
	logic [SYNC_W-1:0]   s2_reg;
	logic                en_d_reg;
	logic [W-1:0]        acc_reg;
	logic [2:0]          rx_beat_reg;
	logic [5:0]          rx_cnt_reg;
	logic [W-1:0]        rx_data_reg;
	logic                rx_valid_reg;
	logic                cell_end_reg;
	logic [fpa_pkg::IDENT_W-1:0] code_reg;
	logic [fpa_pkg::IDENT_W-1:0] err_code_reg;
	logic                err_flag_reg;
	logic                port_a_bit_13_out_reg;
	logic                port_a_bit_13_oe_reg;

	// ------------------------------------------------------------
	// Transmit queue
	// ------------------------------------------------------------
	wire [W-1:0] q_data;
	wire         q_valid;
	wire         q_ready;

	fpa_fifo #(
		.WIDTH (W),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.ce        (ce),
		.in_data   (tx_data),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.out_data  (q_data),
		.out_valid (q_valid),
		.out_ready (q_ready)
	);

	// ------------------------------------------------------------
	// Transmit octet selection
	// ------------------------------------------------------------
	wire       is_uto   = (mode_reg == fpa_pkg::MODE_UTOPIA);
	wire       is_nib   = (mode_reg == fpa_pkg::MODE_NIBBLE);
	wire       is_ser   = (mode_reg == fpa_pkg::MODE_SERIAL);
	wire [2:0] beat_last = is_uto ? fpa_pkg::BEATS_UTO :
			       is_nib ? fpa_pkg::BEATS_NIB : fpa_pkg::BEATS_SER;
	wire       tx_load  = (mode_reg != fpa_pkg::MODE_OFF) && (beat_reg == beat_last);
	wire       cell_top = (tx_cnt_reg == '0);
	wire       want_q   = is_uto ? (cell_top || kind_reg == fpa_pkg::CELL_DATA) : 1'b1;
	wire       use_q    = want_q && q_valid;
	wire       underrun = tx_load && is_uto && !cell_top
			      && kind_reg == fpa_pkg::CELL_DATA && !q_valid;
	wire [W-1:0] idle_oct = (tx_cnt_reg == fpa_pkg::IDLE_HDR_IDX) ? fpa_pkg::IDLE_HDR_OCT :
				(tx_cnt_reg == fpa_pkg::IDLE_HEC_IDX) ? fpa_pkg::IDLE_HEC_OCT :
				(tx_cnt_reg >  fpa_pkg::IDLE_HEC_IDX) ? fpa_pkg::IDLE_PAY_OCT :
				fpa_pkg::ZERO_OCT;
	// Idle cell when nothing is queued at a cell boundary
	wire [W-1:0] fill_oct = is_uto ? (kind_next == fpa_pkg::CELL_DATA ? fpa_pkg::IDLE_PAY_OCT
						: idle_oct) : fpa_pkg::FLAG_OCT;
	assign kind_next = (is_uto && cell_top) ? (q_valid ? fpa_pkg::CELL_DATA : fpa_pkg::CELL_IDLE)
					: kind_reg;
	assign q_ready   = tx_load && want_q;

	// Octet shifter: whole octet, high nibble first, or high bit first
	always_comb
	begin
		if (tx_load)
			sh_next = use_q ? q_data : fill_oct;
		else if (is_nib)
			sh_next = {sh_reg[3:0], 4'h0};
		else if (is_ser)
			sh_next = {sh_reg[6:0], 1'b0};
		else
			sh_next = sh_reg;
	end

	// Pin image of the octet now in the shifter, one function per pin
	genvar gi;
	generate
		for (gi = 0; gi < fpa_pkg::TX_PINS; gi++)
		begin : g_tx_pin
			if (gi < 4)
			begin : g_nib
				assign pin_next[gi] = is_uto ? sh_reg[W-1-gi] :
						      is_nib ? sh_reg[4+gi] :
						      (is_ser && gi == 0) ? sh_reg[W-1] : 1'b0;
			end
			else
			begin : g_uto
				assign pin_next[gi] = is_uto ? sh_reg[W-1-gi] : 1'b0;
			end
		end
	endgenerate

	wire [fpa_pkg::TX_PINS-1:0] oe_next = is_uto ? 5'h1F : is_nib ? 5'h0F :
					      is_ser ? 5'h01 : 5'h00;

	// Mode and transmit state
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			mode_reg     <= fpa_pkg::MODE_OFF;
			kind_reg     <= fpa_pkg::CELL_IDLE;
			sh_reg       <= '0;
			beat_reg     <= '0;
			tx_cnt_reg   <= '0;
			pin_out_reg  <= '0;
			pin_oe_reg   <= '0;
			underrun_reg <= 1'b0;
		end
		else if (ce)
		begin
			mode_reg     <= lane_mode;
			sh_reg       <= sh_next;
			pin_out_reg  <= pin_next;
			pin_oe_reg   <= oe_next;
			underrun_reg <= underrun;
			beat_reg     <= (tx_load || mode_reg != lane_mode) ? 3'h0 : 3'(beat_reg + 1'b1);
			if (tx_load)
				kind_reg <= kind_next;
			if (!is_uto)
				tx_cnt_reg <= '0;
			else if (tx_load)
				tx_cnt_reg <= (tx_cnt_reg == fpa_pkg::CELL_LAST) ? 6'h00
					      : 6'(tx_cnt_reg + 1'b1);
		end
	end

	// ------------------------------------------------------------
	// Receive pin synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
		end
		else if (ce)
		begin
			s1_reg <= {rx_enable_strobe, rx_low_in, rx_pin_in};
			s2_reg <= s1_reg;
		end
	end

	// ------------------------------------------------------------
	// Receive lane decode
	// ------------------------------------------------------------
	wire [fpa_pkg::RX_PINS-1:0] rp  = s2_reg[fpa_pkg::RX_PINS-1:0];
	wire [fpa_pkg::RX_LOW-1:0]  rl  = s2_reg[fpa_pkg::RX_PINS +: fpa_pkg::RX_LOW];
	wire                        ren = s2_reg[SYNC_W-1];
	wire                        lane3 = port_a_bit_13_oe_reg ? 1'b0 : rp[0];
	wire [W-1:0] rx_oct = {rp[4], rp[3], rp[2], rp[1], lane3, rl};
	wire [3:0]   rx_nib = {rp[1], rp[2], rp[3], rp[4]};
	wire         rx_bit = rp[4];
	wire         rx_take = is_uto ? en_d_reg : (is_nib || is_ser);
	wire [2:0]   rx_last = is_nib ? fpa_pkg::BEATS_NIB : fpa_pkg::BEATS_SER;
	wire [W-1:0] acc_next = is_nib ? {acc_reg[3:0], rx_nib} : {acc_reg[6:0], rx_bit};
	wire         rx_done = is_uto ? rx_take : (rx_take && rx_beat_reg == rx_last);

	// Receive assembly and cell framing
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			en_d_reg     <= 1'b0;
			acc_reg      <= '0;
			rx_beat_reg  <= '0;
			rx_cnt_reg   <= '0;
			rx_data_reg  <= '0;
			rx_valid_reg <= 1'b0;
			cell_end_reg <= 1'b0;
		end
		else if (ce)
		begin
			en_d_reg     <= ren && is_uto;
			rx_valid_reg <= rx_done;
			cell_end_reg <= rx_done && is_uto && rx_cnt_reg == fpa_pkg::CELL_LAST;
			if (rx_take && !is_uto)
				acc_reg <= acc_next;
			if (!rx_take || is_uto || rx_done)
				rx_beat_reg <= '0;
			else
				rx_beat_reg <= 3'(rx_beat_reg + 1'b1);
			if (rx_done)
				rx_data_reg <= is_uto ? rx_oct : acc_next;
			if (!is_uto)
				rx_cnt_reg <= '0;
			else if (rx_done)
				rx_cnt_reg <= (rx_cnt_reg == fpa_pkg::CELL_LAST) ? 6'h00
					      : 6'(rx_cnt_reg + 1'b1);
		end
	end

	// ------------------------------------------------------------
	// Identity code, error capture and pin 13
	// ------------------------------------------------------------
	wire [fpa_pkg::IDENT_W-1:0] code_next = {ident_rx_section, ident_sub_code};

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			code_reg     <= '0;
			err_code_reg <= '0;
			err_flag_reg <= 1'b0;
			port_a_bit_13_out_reg <= 1'b0;
			port_a_bit_13_oe_reg  <= 1'b0;
		end
		else if (ce)
		begin
			code_reg     <= code_next;
			port_a_bit_13_out_reg <= ident_sel && code_reg[fpa_pkg::IDENT_PIN];
			port_a_bit_13_oe_reg  <= ident_sel;
			if (dma_error)
				err_code_reg <= code_reg;
			err_flag_reg <= dma_error || (err_flag_reg && !err_clear);
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign tx_pin_out        = pin_out_reg;
	assign tx_pin_oe         = pin_oe_reg;
	assign tx_underrun       = underrun_reg;
	assign rx_data           = rx_data_reg;
	assign rx_valid          = rx_valid_reg;
	assign rx_cell_end       = cell_end_reg;
	assign module_ident_code = code_reg;
	assign err_ident_code    = err_code_reg;
	assign err_flag          = err_flag_reg;
	assign port_a_bit_13_out = port_a_bit_13_out_reg;
	assign port_a_bit_13_oe  = port_a_bit_13_oe_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	sequence s_uto_step;
		ce && is_uto && mode_reg == lane_mode;
	endsequence

	a_tx_cell_len: assert property (tx_cnt_reg <= fpa_pkg::CELL_LAST)
		else $error("transmit cell counter past 53 octets");
	a_rx_cell_len: assert property (rx_cnt_reg <= fpa_pkg::CELL_LAST)
		else $error("receive cell counter past 53 octets");
	a_uto_lanes: assert property (s_uto_step |=> tx_pin_out ==
		{$past(sh_reg[3]), $past(sh_reg[4]), $past(sh_reg[5]), $past(sh_reg[6]), $past(sh_reg[7])})
		else $error("cell lanes out of order");
	a_idle_cell: assert property ((s_uto_step ##0 tx_load && cell_top && !q_valid)
		|=> kind_reg == fpa_pkg::CELL_IDLE && sh_reg == fpa_pkg::ZERO_OCT)
		else $error("idle cell not started");
	a_nib_lanes: assert property (ce && is_nib |=> tx_pin_out[3:0] == $past(sh_reg[7:4])
		&& tx_pin_oe == 5'h0F)
		else $error("nibble lanes wrong");
	a_ser_lane: assert property (ce && is_ser |=> tx_pin_out == {4'h0, $past(sh_reg[7])})
		else $error("serial lane wrong");
	a_rx_after_en: assert property (ce && is_uto && !ren ##1 ce && is_uto |=> !rx_valid)
		else $error("octet taken without receive enable");
	a_ident_pin: assert property (ce ##1 ce |=> port_a_bit_13_out ==
		($past(ident_sel) && $past(code_reg[2])))
		else $error("pin 13 code bit wrong");
	a_err_capture: assert property (ce && dma_error |=> err_flag && err_ident_code == $past(code_reg))
		else $error("identity code not captured");
	a_pin13_excl: assert property (port_a_bit_13_oe && ce && is_uto |=> !rx_data_reg[3] || !rx_valid)
		else $error("pin 13 used twice");

endmodule
`default_nettype wire

// file: sim/fpa_phy_model.sv
`default_nettype none
module fpa_phy_model (
	input  wire logic       clk_sys,
	input  wire logic       ce,
	input  wire logic [4:0] tx_pin_out,
	output logic      [4:0] rx_pin_in,
	output logic      [2:0] rx_low_in,
	output logic            rx_enable_strobe
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [4:0] hist [$];    // Transmit pin samples
	logic [7:0] cell_q [$];  // Octets of the cell on offer
	logic [7:0] stat_val;    // Held lane levels outside cells
	logic [7:0] stat_mask;   // Lanes that toggle while held
	logic       stat_on;
	logic       toggle;
	int         n_left;
	int         gap_at;
	int         gap_cnt;

	// Idle at time zero
	initial
	begin
		rx_pin_in = 5'h00;
		rx_low_in = 3'h0;
		rx_enable_strobe = 1'h0;
		stat_on = 1'h0;
		toggle = 1'h0;
		n_left = 0;
		gap_at = 0;
		gap_cnt = 0;
	end

	// Record what the device puts on its transmit pins
	always @(posedge clk_sys)
		if (ce)
			hist.push_back(tx_pin_out);

	// Offer a cell: strobe first, lanes driven in the cycle after each strobe
	always @(posedge clk_sys)
	begin
		toggle <= ~toggle;
		if (rx_enable_strobe)
			{rx_pin_in, rx_low_in} <= cell_q.pop_front();
		else if (stat_on)
			{rx_pin_in, rx_low_in} <= stat_val ^ (stat_mask & {8{toggle}});
		else
			{rx_pin_in, rx_low_in} <= ~{rx_pin_in, rx_low_in};
		if (n_left > 0 && !(n_left == gap_at && gap_cnt < 3))
		begin
			rx_enable_strobe <= 1'h1;
			n_left <= n_left - 1;
		end
		else
		begin
			rx_enable_strobe <= 1'h0;
			gap_cnt <= gap_cnt + 1;
		end
	end
endmodule
`default_nettype wire

// file: sim/fpa_lanes_bench.sv
`default_nettype none
`define CHK(got, exp, msg) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) \
		begin \
			bad_count++; \
			$display("FAIL %0t %s", $time, msg); \
		end \
	end
module fpa_lanes_bench;
	timeunit 1ns;
	timeprecision 1ns;

	logic               clk_sys, srst, ce, ident_sel, tx_valid, tx_ready, tx_underrun;
	logic               rx_enable_strobe, rx_valid, rx_cell_end, ident_rx_section;
	logic               dma_error, err_clear, err_flag, port_a_bit_13_out, port_a_bit_13_oe;
	fpa_pkg::fpa_mode_t lane_mode;
	logic [7:0]         tx_data, rx_data;
	logic [4:0]         tx_pin_out, tx_pin_oe, rx_pin_in, ident_sub_code;
	logic [2:0]         rx_low_in;
	logic [5:0]         module_ident_code, err_ident_code;
	int                 bad_count = 0;
	int                 comparisons = 0;
	int                 cycles = 0;
	int                 underruns = 0;
	int                 ends_at [$];
	logic [7:0]         rxq [$];
	logic [7:0]         txq [$];

	fpa_lanes uut (
		.clk_sys(clk_sys), .srst(srst), .ce(ce), .lane_mode(lane_mode), .ident_sel(ident_sel),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_underrun(tx_underrun),
		.tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .rx_pin_in(rx_pin_in),
		.rx_low_in(rx_low_in), .rx_enable_strobe(rx_enable_strobe), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_cell_end(rx_cell_end), .ident_sub_code(ident_sub_code),
		.ident_rx_section(ident_rx_section), .dma_error(dma_error), .err_clear(err_clear),
		.module_ident_code(module_ident_code), .err_ident_code(err_ident_code),
		.err_flag(err_flag), .port_a_bit_13_out(port_a_bit_13_out),
		.port_a_bit_13_oe(port_a_bit_13_oe)
	);

	fpa_phy_model phy (
		.clk_sys(clk_sys), .ce(ce), .tx_pin_out(tx_pin_out), .rx_pin_in(rx_pin_in),
		.rx_low_in(rx_low_in), .rx_enable_strobe(rx_enable_strobe)
	);

	// Clock
	initial
	begin
		clk_sys = 1'h0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Collect received octets, count underruns, cut a hang short
	always @(posedge clk_sys)
	begin
		cycles++;
		if (rx_valid === 1'h1)
		begin
			if (rx_cell_end === 1'h1)
				ends_at.push_back(rxq.size());
			rxq.push_back(rx_data);
		end
		if (tx_underrun === 1'h1)
			underruns++;
		if (cycles > 6000)
		begin
			bad_count++;
			report_and_stop();
		end
	end

	// Cell octet as seen on pins 22..18
	function automatic logic [4:0] pins(input logic [7:0] o);
		return {o[3], o[4], o[5], o[6], o[7]};
	endfunction

	// Idle cell octet i; past the header it is the fill octet
	function automatic logic [7:0] idle_oct(input int i);
		return i == 3 ? fpa_pkg::IDLE_HDR_OCT : i == 4 ? fpa_pkg::IDLE_HEC_OCT
			: i < 3 ? fpa_pkg::ZERO_OCT : fpa_pkg::IDLE_PAY_OCT;
	endfunction

	// First index of seq in the pin record, under mask, or -1
	function automatic int find(input logic [4:0] mask, input logic [4:0] seq [$], input int from);
		int k;
		for (int i = from; i + seq.size() <= phy.hist.size(); i++)
		begin
			for (k = 0; k < seq.size() && (phy.hist[i + k] & mask) === seq[k]; k++);
			if (k == seq.size())
				return i;
		end
		return -1;
	endfunction

	task automatic set_mode(input fpa_pkg::fpa_mode_t m);
		@(posedge clk_sys);
		lane_mode <= m;
		repeat (4) @(posedge clk_sys);
	endtask

	// Push txq through valid/ready; reports how many went in before the first refusal
	task automatic push_all(output int first_ref);
		int i;
		first_ref = -1;
		i = 0;
		@(posedge clk_sys);
		tx_valid <= 1'h1;
		tx_data <= txq[0];
		while (i < txq.size() && cycles < 6000)
		begin
			@(posedge clk_sys);
			if (tx_ready === 1'h1)
			begin
				i++;
				tx_data <= txq[i % txq.size()];
			end
			else if (first_ref < 0)
				first_ref = i;
		end
		tx_valid <= 1'h0;
	endtask

	// Nibble or serial lanes: width w per beat, enables oe
	task automatic lane_test(input fpa_pkg::fpa_mode_t m, input logic [4:0] oe, input int w);
		logic [4:0] seq [$];
		logic [7:0] r, e, v, msk;
		int i, b, base;
		set_mode(m);
		`CHK(tx_pin_oe, oe, "lane oe");
		for (i = 0; i < 8 / w; i++)
			seq.push_back(5'((8'hC3 >> (8 - w * (i + 1))) & 8'(oe)));
		base = phy.hist.size();
		txq = {8'hC3};
		push_all(b);
		for (i = 0; i < 300 && find(oe, seq, base) < 0; i++)
			@(posedge clk_sys);
		`CHK(find(oe, seq, base) >= 0, 1'h1, "lane transmit");
		for (b = 0; b < 2; b++)
		begin
			r = 8'($urandom);
			v = 8'h00;
			msk = 8'hFF;
			for (i = 0; i < 8; i++)
				e[i] = r[i % w];
			for (i = 0; i < w; i++)
			begin
				v[7 - i] = r[i];
				msk[7 - i] = 1'h0;
			end
			@(negedge clk_sys);
			phy.stat_val = v;
			phy.stat_mask = msk;
			phy.stat_on = 1'h1;
			repeat (12) @(posedge clk_sys);
			@(negedge clk_sys);
			rxq.delete();
			repeat (24) @(posedge clk_sys);
			`CHK(rxq.size() >= 2, 1'h1, "lane receive count");
			foreach (rxq[j]) `CHK(rxq[j], e, "lane receive");
		end
	endtask

	task automatic report_and_stop();
		if (bad_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		logic [4:0] ih [$];
		logic [4:0] one [$];
		logic [4:0] ep [$];
		logic [5:0] code;
		int i, a, k, ref_at, seed;
		seed = $urandom(64);
		{srst, ce, ident_sel, tx_valid, ident_rx_section, dma_error, err_clear} = 7'h60;
		lane_mode = fpa_pkg::MODE_OFF;
		tx_data = 8'h00;
		ident_sub_code = 5'h00;
		repeat (4) @(posedge clk_sys);
		`CHK({tx_ready, tx_pin_oe, rx_valid, err_flag, module_ident_code}, 14'h2000, "reset");
		srst <= 1'h0;
		// Cell transmit: full cell, short cell, then idle cells
		set_mode(fpa_pkg::MODE_UTOPIA);
		`CHK(tx_pin_oe, 5'h1F, "cell oe");
		for (i = 0; i < 5; i++)
			ih.push_back(pins(idle_oct(i)));
		one.push_back(5'h1F);
		for (i = 0; i < 200 && find(5'h1F, ih, 0) < 0; i++)
			@(posedge clk_sys);
		txq = {8'hFF};
		for (i = 1; i < 63; i++)
			txq.push_back(8'($urandom));
		for (i = 0; i < 112; i++)
			ep.push_back(pins(i < 63 ? txq[i] : idle_oct(i < 106 ? 5 : i - 106)));
		push_all(ref_at);
		// Queue words plus the registered read stage
		`CHK(ref_at, fpa_pkg::FIFO_DEPTH + 1, "queue full");
		for (i = 0; i < 300; i++)
		begin
			a = find(5'h1F, one, 0);
			if (a >= 0 && phy.hist.size() >= a + 112)
				break;
			@(posedge clk_sys);
		end
		`CHK(a >= 0, 1'h1, "cell start");
		if (a >= 0)
			for (i = 0; i < 112; i++) `CHK(phy.hist[a + i], ep[i], "cell stream");
		k = find(5'h1F, ih, 0);
		`CHK((a - k) % 53, 0, "cell boundary");
		`CHK(underruns > 0, 1'h1, "underrun");
		`CHK(tx_ready, 1'h1, "queue drained");
		// Cell receive with a pause in the strobe, then with pin 13 as code output
		for (k = 0; k < 2; k++)
		begin
			ident_sel <= 1'(k);
			txq.delete();
			for (i = 0; i < 53; i++)
				txq.push_back(8'($urandom));
			@(negedge clk_sys);
			rxq.delete();
			phy.cell_q = txq;
			phy.gap_at = 20;
			phy.gap_cnt = 0;
			phy.n_left = 53;
			for (i = 0; i < 200 && rxq.size() < 53; i++)
				@(posedge clk_sys);
			repeat (6) @(posedge clk_sys);
			`CHK(rxq.size(), 53, "rx count");
			foreach (rxq[j]) `CHK(rxq[j], txq[j] & ~{4'h0, 1'(k), 3'h0}, "rx octet");
			`CHK(ends_at.size() == k + 1 && ends_at[k] == 52, 1'h1, "cell end");
		end
		ident_sel <= 1'h0;
		lane_test(fpa_pkg::MODE_NIBBLE, 5'h0F, 4);
		lane_test(fpa_pkg::MODE_SERIAL, 5'h01, 1);
		// Identity code, pin 13 output and error capture
		for (i = 0; i < 8; i++)
		begin
			@(posedge clk_sys);
			ident_sub_code <= 5'($urandom);
			ident_rx_section <= 1'($urandom);
			ident_sel <= 1'($urandom);
			repeat (3) @(posedge clk_sys);
			code = {ident_rx_section, ident_sub_code};
			`CHK(module_ident_code, code, "ident code");
			`CHK(port_a_bit_13_out, ident_sel & code[2], "ident pin");
			`CHK(port_a_bit_13_oe, ident_sel, "ident pin oe");
			dma_error <= 1'h1;
			err_clear <= 1'(i);
			@(posedge clk_sys);
			dma_error <= 1'h0;
			err_clear <= 1'h0;
			repeat (2) @(posedge clk_sys);
			`CHK(err_ident_code, code, "error capture");
			`CHK(err_flag, 1'h1, "error flag");
			err_clear <= 1'h1;
			@(posedge clk_sys);
			err_clear <= 1'h0;
			repeat (2) @(posedge clk_sys);
			`CHK(err_flag, 1'h0, "error clear");
		end
		// Clock enable low freezes the code register, high lets it follow again
		@(posedge clk_sys);
		ce <= 1'h0;
		ident_sub_code <= ~ident_sub_code;
		repeat (3) @(posedge clk_sys);
		`CHK(module_ident_code, code, "ce freeze");
		ce <= 1'h1;
		repeat (3) @(posedge clk_sys);
		`CHK(module_ident_code, {ident_rx_section, ident_sub_code}, "ce resume");
		report_and_stop();
	end
endmodule
`default_nettype wire
